/* File: logic/rta_top.sv */
// How it works
// - two-bit select picks 4096, 64, 1 Hz, minute
// - interval equals source period times preset count
// - first interval may be one period short
// - run rising starts count, falling stops it
// - decrement per tick, event on a tick at 01h, which reloads the preset
// - event sets sticky timer flag until cleared
// - level mode drives interrupt when enable set
// - level mode enable toggles output while flag set
// - clearing timer flag releases level interrupt
// - reload preset and keep counting while running
// - repeated mode reloads preset automatically
// - repeated mode drives fixed-length low pulse
// - clearing flag never shortens the pulse
// - each later event pulses even flag set
// - alarm match sets sticky alarm flag
// - alarm enable drives interrupt until cleared
// - dropping alarm enable releases output immediately
// - clearing alarm flag releases output immediately
// - ignore bits exclude fields, all ignored none
// - raising alarm enable with flag drives low
// - alarm fires on entering match only
// - writing one to timer flag does nothing
`default_nettype none
module rta_top
  import rta_pkg::*;
#(
  parameter int DIV_4K    = DIV_4K_DEF,
  parameter int PULSE_CYC = PULSE_CYC_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        minute_tick_i,
  input  wire logic [6:0]  cur_min_i,
  input  wire logic [5:0]  cur_hour_i,
  input  wire logic [5:0]  cur_day_i,
  input  wire logic [2:0]  cur_wday_i,
  output logic             int_n_o,
  output logic             int_n_oe_o
);
  localparam int QW = $clog2(PULSE_CYC + 1);

  generate
    if (DIV_4K < 2 || PULSE_CYC < 1) begin : g_bad
      $error("rta_top: DIV_4K must be 2 or more, PULSE_CYC 1 or more");
    end
  endgenerate

  logic [5:0]  idx;
  logic        aligned;
  logic        acc;
  logic        wr;
  logic        w_ctrl2;
  logic        w_tctrl;
  logic        w_preset;
  logic [7:0]  wd;
  logic [7:0]  rd;

  logic        tie_r;
  logic        aie_r;
  logic        pmode_r;
  logic        tflag_r;
  logic        aflag_r;
  logic        run_r;
  logic [1:0]  sel_r;
  logic [7:0]  preset_r;
  logic [7:0]  cnt_r;
  logic [QW-1:0] pcnt_r;
  logic        match_r;

  logic        tick;
  logic        start;
  logic        t_evt;
  logic        pulse_act;
  logic        a_evt;
  logic        match;
  logic        all_ign;
  logic        t_req;
  logic        a_req;

  logic [7:0]        cur [NFIELD];
  logic [7:0]        alm_r [NFIELD];
  logic [NFIELD-1:0] fmatch;
  logic [NFIELD-1:0] ign;

  // bus decode
  assign acc     = wb_cyc_i & wb_stb_i;
  assign idx     = wb_adr_i[7:2];
  assign aligned = (wb_adr_i[1:0] == 2'h0);
  assign wr      = acc & wb_we_i & wb_ack_o & wb_sel_i[0] & aligned;
  assign wd      = wb_dat_i[7:0];
  assign w_ctrl2  = wr & (idx == IDX_CTRL2);
  assign w_tctrl  = wr & (idx == IDX_TCTRL);
  assign w_preset = wr & (idx == IDX_PRESET);

  assign cur[0] = {1'b0, cur_min_i};
  assign cur[1] = {2'h0, cur_hour_i};
  assign cur[2] = {2'h0, cur_day_i};
  assign cur[3] = {5'h00, cur_wday_i};

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc & ~wb_ack_o;
    end
  end

  // read data captured before ack, stable while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (acc & ~wb_ack_o) begin
      wb_dat_o <= {24'h000000, aligned ? rd : BYTE_RST};
    end
  end

  always_comb begin
    rd = BYTE_RST;
    case (idx)
      IDX_CTRL2: begin
        rd[B_PMODE] = pmode_r;
        rd[B_AF]    = aflag_r;
        rd[B_TF]    = tflag_r;
        rd[B_AIE]   = aie_r;
        rd[B_TIE]   = tie_r;
      end
      IDX_TCTRL: begin
        rd[B_RUN]   = run_r;
        rd[B_SELHI] = sel_r[1];
        rd[B_SELLO] = sel_r[0];
      end
      // live count while running, preset otherwise
      IDX_PRESET: rd = run_r ? cnt_r : preset_r;
      IDX_CUR0:            rd = cur[0];
      IDX_CUR0 + 6'h01:    rd = cur[1];
      IDX_CUR0 + 6'h02:    rd = cur[2];
      IDX_CUR0 + 6'h03:    rd = cur[3];
      IDX_ALM0:            rd = alm_r[0];
      IDX_ALM0 + 6'h01:    rd = alm_r[1];
      IDX_ALM0 + 6'h02:    rd = alm_r[2];
      IDX_ALM0 + 6'h03:    rd = alm_r[3];
      default:             rd = BYTE_RST;
    endcase
  end

  // control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tie_r   <= 1'b0;
      aie_r   <= 1'b0;
      pmode_r <= 1'b0;
    end else if (w_ctrl2) begin
      tie_r   <= wd[B_TIE];
      aie_r   <= wd[B_AIE];
      pmode_r <= wd[B_PMODE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
      sel_r <= SEL_4K;
    end else if (w_tctrl) begin
      run_r <= wd[B_RUN];
      sel_r <= {wd[B_SELHI], wd[B_SELLO]};
    end
  end

  // preset is meant to be written with run low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preset_r <= BYTE_RST;
    end else if (w_preset) begin
      preset_r <= wd;
    end
  end

  rta_src_tick #(
    .DIV_4K (DIV_4K)
  ) u_tick (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .sel_i         (sel_r),
    .minute_tick_i (minute_tick_i),
    .tick_o        (tick)
  );

  // down counter
  assign start = w_tctrl & wd[B_RUN] & ~run_r;
  assign t_evt = run_r & tick & (cnt_r == CNT_ONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= CNT_ZERO;
    end else if (start) begin
      cnt_r <= preset_r;
    end else if (run_r && tick) begin
      if (cnt_r == CNT_ONE) begin
        cnt_r <= preset_r;
      end else if (cnt_r != CNT_ZERO) begin
        cnt_r <= cnt_r - CNT_ONE;
      end
    end
  end

  // timer flag: event wins over clear, writing one is ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tflag_r <= 1'b0;
    end else if (t_evt) begin
      tflag_r <= 1'b1;
    end else if (w_ctrl2 && !wd[B_TF]) begin
      tflag_r <= 1'b0;
    end
  end

  // repeated-mode pulse, independent of the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcnt_r <= '0;
    end else if (t_evt && pmode_r && tie_r) begin
      pcnt_r <= QW'(PULSE_CYC);
    end else if (pulse_act) begin
      pcnt_r <= pcnt_r - QW'(1);
    end
  end

  assign pulse_act = (pcnt_r != '0);

  // alarm compare and register writes per field
  genvar gi;
  generate
    for (gi = 0; gi < NFIELD; gi++) begin : g_fld
      localparam logic [5:0] FIDX = IDX_ALM0 + 6'(gi);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          alm_r[gi] <= ALM_RST;
        end else if (wr && idx == FIDX) begin
          alm_r[gi] <= wd;
        end
      end
      assign ign[gi]    = alm_r[gi][B_AE];
      assign fmatch[gi] = ign[gi] |
        ((alm_r[gi] & FMASK[gi]) == (cur[gi] & FMASK[gi]));
    end
  endgenerate

  assign all_ign = &ign;
  assign match   = (&fmatch) & ~all_ign;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_r <= 1'b0;
    end else begin
      match_r <= match;
    end
  end

  assign a_evt = match & ~match_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aflag_r <= 1'b0;
    end else if (a_evt) begin
      aflag_r <= 1'b1;
    end else if (w_ctrl2 && !wd[B_AF]) begin
      aflag_r <= 1'b0;
    end
  end

  // interrupt requests
  assign t_req = pmode_r ? pulse_act : (tflag_r & tie_r);
  assign a_req = aflag_r & aie_r;
  assign int_n_o    = 1'b0;
  assign int_n_oe_o = t_req | a_req;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_START_LOAD: assert property (
    $rose(run_r) |-> cnt_r == $past(preset_r))
    else $error("start did not load preset");
  AST_STOP_HOLD: assert property (
    !run_r && !$past(run_r) |-> $stable(cnt_r))
    else $error("counter moved while stopped");
  AST_DECREMENT: assert property (
    run_r && tick && cnt_r > CNT_ONE |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("counter did not decrement");
  AST_EVENT_FLAG: assert property (
    t_evt |=> tflag_r && cnt_r == $past(preset_r))
    else $error("event missed flag or reload");
  AST_FLAG_HOLD: assert property (
    tflag_r && !(w_ctrl2 && !wd[B_TF]) |=> tflag_r)
    else $error("timer flag lost");
  AST_W1_TF: assert property (
    !tflag_r && !t_evt |=> !tflag_r)
    else $error("timer flag set without event");
  AST_LEVEL_IRQ: assert property (
    !pmode_r && tflag_r && tie_r |-> int_n_oe_o)
    else $error("level interrupt not driven");
  AST_LEVEL_REL: assert property (
    !pmode_r && !tflag_r && !a_req |-> !int_n_oe_o)
    else $error("level interrupt not released");
  AST_PULSE_LOAD: assert property (
    t_evt && pmode_r && tie_r |=> pcnt_r == QW'(PULSE_CYC))
    else $error("pulse not started");
  AST_PULSE_HOLD: assert property (
    pmode_r && pulse_act |-> int_n_oe_o)
    else $error("pulse cut short");
  AST_ALM_EDGE: assert property (
    a_evt |-> !match_r ##1 aflag_r)
    else $error("alarm event not on entry");
  AST_ALM_IGN: assert property (
    all_ign |-> !a_evt)
    else $error("alarm with all fields ignored");
  AST_ALM_IRQ: assert property (
    aflag_r && aie_r |-> int_n_oe_o)
    else $error("alarm interrupt not driven");

  COV_LEVEL: cover property (!pmode_r && t_evt && tie_r);
  COV_REPEAT: cover property (pmode_r && t_evt ##[1:1000] t_evt);
  COV_ALARM: cover property (a_evt && aie_r);
endmodule
`default_nettype wire

/* File: pkg/rta_pkg.sv */
`default_nettype none
package rta_pkg;
  // clock and source rates
  localparam int CLK_HZ     = 50_000_000;
  localparam int SRC_HZ     = 4096;
  localparam int DIV_4K_DEF = CLK_HZ / SRC_HZ;
  // repeated-mode low pulse
  localparam int PULSE_LOW_US  = 1000;
  localparam int PULSE_CYC_DEF = PULSE_LOW_US * (CLK_HZ / 1_000_000);
  // cascade 4096 -> 64 -> 1 Hz, each step divides by 64
  localparam int          STEP_W   = 6;
  localparam logic [5:0]  STEP_MAX = 6'h3F;
  // source clock select codes
  localparam logic [1:0] SEL_4K  = 2'h0;
  localparam logic [1:0] SEL_64  = 2'h1;
  localparam logic [1:0] SEL_1HZ = 2'h2;
  localparam logic [1:0] SEL_MIN = 2'h3;
  // register indexes, byte address is four times the index
  localparam logic [5:0] IDX_CTRL2  = 6'h01;
  localparam logic [5:0] IDX_CUR0   = 6'h03;
  localparam logic [5:0] IDX_ALM0   = 6'h09;
  localparam logic [5:0] IDX_TCTRL  = 6'h0E;
  localparam logic [5:0] IDX_PRESET = 6'h0F;
  localparam int         NFIELD     = 4;
  // control 2 bits
  localparam int B_PMODE = 4;
  localparam int B_AF    = 3;
  localparam int B_TF    = 2;
  localparam int B_AIE   = 1;
  localparam int B_TIE   = 0;
  // timer control bits
  localparam int B_RUN   = 7;
  localparam int B_SELHI = 1;
  localparam int B_SELLO = 0;
  // alarm field ignore bit and reset value
  localparam int         B_AE    = 7;
  localparam logic [7:0] ALM_RST = 8'h80;
  // field masks: minute, hour, day, weekday
  localparam logic [7:0] FMASK [NFIELD] = '{8'h7F, 8'h3F, 8'h3F, 8'h07};
  localparam logic [7:0] CNT_ONE  = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage
`default_nettype wire

/* File: logic/rta_src_tick.sv */
`default_nettype none
module rta_src_tick
  import rta_pkg::*;
#(
  parameter int DIV_4K = DIV_4K_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       minute_tick_i,
  output var  logic       tick_o
);
  localparam int PW = $clog2(DIV_4K);

  logic [PW-1:0]     pre_r;
  logic [STEP_W-1:0] c64_r;
  logic [STEP_W-1:0] c1_r;
  logic              t4k;
  logic              t64;
  logic              t1;

  // free-running prescaler, so the first interval may be short
  assign t4k = (pre_r == PW'(DIV_4K - 1));
  assign t64 = t4k && (c64_r == STEP_MAX);
  assign t1  = t64 && (c1_r == STEP_MAX);

  always_ff @(posedge clk_i) begin
    if (rst_i || t4k) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c64_r <= '0;
    end else if (t4k) begin
      c64_r <= c64_r + STEP_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_r <= '0;
    end else if (t64) begin
      c1_r <= c1_r + STEP_W'(1);
    end
  end

  // source select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      case (sel_i)
        SEL_4K:  tick_o <= t4k;
        SEL_64:  tick_o <= t64;
        SEL_1HZ: tick_o <= t1;
        SEL_MIN: tick_o <= minute_tick_i;
        default: tick_o <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verification/rta_pin_model.sv */
`default_nettype none
module rta_pin_model (
  input  wire logic int_n_i,
  input  wire logic oe_i,
  output var  logic irq_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // host side pull-up: the line reads low only while the device drives it
  assign irq_n_o = oe_i ? int_n_i : 1'b1;
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none
module tb
  import rta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4;
  localparam int PW  = 5;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        mtick = 1'b0;
  logic [3:0]  sel;
  logic        oe;
  logic        int_n;
  logic        irq_n;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [6:0]  cmin;
  logic [5:0]  chour;
  logic [31:0] exp_q[$];
  int          err_count;
  int          total_checks;
  int          run_w = 0;
  int          last_w = 0;
  int          cyc_n = 0;

  rta_top #(.DIV_4K(DIV), .PULSE_CYC(PW)) u_dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .minute_tick_i(mtick), .cur_min_i(cmin),
    .cur_hour_i(chour), .cur_day_i(6'h01), .cur_wday_i(3'h1),
    .int_n_o(int_n), .int_n_oe_o(oe)
  );
  rta_pin_model u_pin (.int_n_i(int_n), .oe_i(oe), .irq_n_o(irq_n));

  always #10 clk = ~clk;

  // minute update every 100 cycles
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    mtick <= (cyc_n % 100 == 99);
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic to();
    cmp(32'h0, 32'h1);
    summarize();
  endtask

  // read data checked against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) cmp(rdat, exp_q.pop_front());
  end

  // width of each low period on the line
  always @(posedge clk) begin
    if (irq_n === 1'b0) begin
      run_w <= run_w + 1;
    end else if (run_w != 0) begin
      last_w <= run_w;
      run_w <= 0;
    end
  end

  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) to();
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask

  task automatic irq_is(input logic e);
    @(posedge clk);
    cmp({31'h0, irq_n}, {31'h0, e});
  endtask

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq_n !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > lim) to();
    end
  endtask

  task automatic wait_hi();
    int n;
    n = 0;
    while (irq_n !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 40) to();
    end
    @(posedge clk);
  endtask

  initial begin
    int         n;
    int         np;
    logic [7:0] pre;
    logic [5:0] h;
    clk = 1'b0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    cmin = 7'h15;
    chour = 6'h00;
    err_count = 0;
    total_checks = 0;
    void'($urandom(32'hB3C6));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_CTRL2, 32'h0);
    rd(IDX_ALM0, 32'h80);
    rd(6'h3F, 32'h0);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      np = (s == 0) ? DIV : (s == 1) ? DIV * 64 : (s == 2) ? DIV * 4096 : 100;
      // fast source needs a longer interval so the clear does not meet the next event
      pre = (s == 0) ? 8'($urandom_range(4, 8)) :
            (s == 1) ? 8'($urandom_range(1, 3)) : 8'h01;
      wr(IDX_TCTRL, 8'h00);
      wr(IDX_CTRL2, 8'h00);
      wr(IDX_PRESET, pre);
      wr(IDX_CTRL2, 8'h01);
      wr(IDX_TCTRL, 8'h80 | 8'(s));
      wait_irq(int'(pre) * np + 8, n);
      cmp({31'h0, n >= (pre - 1) * np && n <= pre * np + 8}, 32'h1);
      rd(IDX_CTRL2, 32'h05);
      wr(IDX_CTRL2, 8'h01);
      irq_is(1'b1);
      wait_irq(int'(pre) * np + 8, n);
      wr(IDX_TCTRL, 8'h00);
      irq_is(1'b0);
      $display("test source %0d done", s);
    end
    wr(IDX_CTRL2, 8'h04);
    irq_is(1'b1);
    wr(IDX_CTRL2, 8'h05);
    irq_is(1'b0);
    wr(IDX_CTRL2, 8'h01);
    irq_is(1'b1);
    rd(IDX_CTRL2, 32'h01);
    $display("test level done");
    wr(IDX_PRESET, 8'h03);
    wr(IDX_CTRL2, 8'h11);
    wr(IDX_TCTRL, 8'h80);
    wait_irq(40, n);
    wait_hi();
    cmp(32'(last_w), 32'(PW));
    wait_irq(40, n);
    wr(IDX_CTRL2, 8'h11);
    wait_hi();
    cmp(32'(last_w), 32'(PW));
    wr(IDX_TCTRL, 8'h00);
    wr(IDX_CTRL2, 8'h00);
    rd(IDX_PRESET, 32'h03);
    $display("test repeated done");
    h = 6'($urandom_range(1, 23));
    wr(IDX_ALM0, 8'h30);
    @(posedge clk);
    cmin <= 7'h30;
    repeat (3) @(posedge clk);
    rd(IDX_CTRL2, 32'h08);
    rd(IDX_CUR0, 32'h30);
    irq_is(1'b1);
    wr(IDX_CTRL2, 8'h0A);
    irq_is(1'b0);
    wr(IDX_CTRL2, 8'h08);
    irq_is(1'b1);
    wr(IDX_CTRL2, 8'h0A);
    irq_is(1'b0);
    wr(IDX_CTRL2, 8'h02);
    irq_is(1'b1);
    repeat (10) @(posedge clk);
    rd(IDX_CTRL2, 32'h02);
    wr(IDX_ALM0, 8'hB0);
    wr(IDX_ALM0 + 6'h01, {2'h0, h});
    @(posedge clk);
    chour <= h;
    repeat (3) @(posedge clk);
    rd(IDX_CTRL2, 32'h0A);
    irq_is(1'b0);
    wr(IDX_CTRL2, 8'h02);
    wr(IDX_ALM0 + 6'h01, 8'h80);
    chour <= 6'h00;
    @(posedge clk);
    chour <= h;
    repeat (3) @(posedge clk);
    rd(IDX_CTRL2, 32'h02);
    $display("test alarm done");
    summarize();
  end
endmodule
`default_nettype wire
